/* File: blit_pkg.sv */
package blit_pkg;

  // register indices on the plain register port
  localparam logic [3:0] LINE_PITCH_IDX   = 4'h0;
  localparam logic [3:0] EXPAND_BG_IDX    = 4'h1;
  localparam logic [3:0] EXPAND_FG_IDX    = 4'h2;
  localparam logic [3:0] MONO_SRC_CTL_IDX = 4'h3;
  localparam logic [3:0] BLIT_CTL_IDX     = 4'h4;
  localparam logic [3:0] PAT_BASE_IDX     = 4'h5;
  localparam logic [3:0] DEST_BASE_IDX    = 4'h7;
  localparam logic [3:0] DEST_EXTENT_IDX  = 4'h8;

  // writable bits of each register except the mono source control, which keeps all 32 bits
  localparam logic [31:0] PITCH_MASK    = 32'h1fff_1fff;
  localparam logic [31:0] COLOR_MASK    = 32'h00ff_ffff;
  localparam logic [31:0] PAT_BASE_MASK = 32'h007f_fff8;
  localparam logic [31:0] DEST_MASK     = 32'h007f_ffff;
  localparam logic [31:0] EXTENT_MASK   = 32'h1fff_1fff;
  localparam logic [31:0] CTL_MASK      = 32'h7fff_ffff;

  // field positions
  localparam int DPITCH_LSB   = 16;
  localparam int DPITCH_MSB   = 28;
  localparam int HEIGHT_LSB   = 16;
  localparam int HEIGHT_MSB   = 28;
  localparam int WIDTH_MSB    = 12;
  localparam int PAT_BASE_LSB = 3;
  localparam int PAT_BASE_MSB = 22;
  localparam int DEST_MSB     = 22;
  localparam int HOST_LANE_MSB = 2;
  localparam int ROP_MSB      = 7;
  localparam int DEST_HOST_BIT = 11;
  localparam int PAT_MONO_BIT = 18;
  localparam int PAT_ROW_LSB  = 20;
  localparam int PAT_ROW_MSB  = 22;
  localparam int DEPTH_LSB    = 24;
  localparam int DEPTH_MSB    = 25;
  localparam int BUSY_BIT     = 31;
  localparam int SRC_SHARED_BIT = 27;

  // colour depth codes
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] DEPTH_24 = 2'h2;

  // pattern geometry
  localparam int PAT_QWORDS      = 32;
  localparam logic [7:0] ROW_BYTES_8  = 8'h08;
  localparam logic [7:0] ROW_BYTES_16 = 8'h10;
  localparam logic [7:0] ROW_BYTES_24 = 8'h20;
  localparam logic [5:0] MONO_QWORDS  = 6'h01;

endpackage

/* File: color_expand.sv */
`timescale 1ns/10ps
// turns one monochrome bit into the selected byte of fg or bg colour
module color_expand #(
  parameter int COLOR_W = 24
) (
  input  wire logic               mono_bit_in,
  input  wire logic [COLOR_W-1:0] fg_in,
  input  wire logic [COLOR_W-1:0] bg_in,
  input  wire logic [1:0]         byte_sel_in,
  output logic      [7:0]         byte_out
);
  logic [COLOR_W-1:0] color;

  always_comb begin
    color    = mono_bit_in ? fg_in : bg_in; // RULE12
    byte_out = color[{byte_sel_in, 3'h0} +: 8]; // RULE13
  end
endmodule

/* File: blit_pattern_fetch.sv */
`timescale 1ns/10ps
// Overview of operation
// RULE1: pattern comes only from frame buffer
// RULE2: pattern is always an 8x8 tile
// RULE3: pattern is mono or 8/16/24 bpp
// RULE4: low three pattern base bits ignored
// RULE5: software quadword-aligns mono patterns
// RULE6: software aligns 8bpp 64B, 16bpp 128B
// RULE7: software aligns 24bpp patterns to 256B
// RULE8: colour footprints are 8/16/32 quadwords
// RULE9: 24bpp rows take 32 bytes each
// RULE10: spare 24bpp bytes sit in row's last quadword
// RULE11: control bit 18 selects mono pattern
// RULE12: bit 1 gives fg, bit 0 gives bg
// RULE13: mono bit expands to depth's byte count
// RULE14: pattern uses shared colours; bit 27 for source
// RULE15: frame-buffer destination may be read-modify-written
// RULE16: destination always at engine colour depth
// RULE17: control bit 11 picks frame buffer or host
// RULE18: host destination uses only base bits 2-0
// RULE19: destination base is frame-buffer byte offset
// RULE20: software sets pitch to row distance
// RULE21: destination pitch in bits 28-16
// RULE22: pattern base in bits 22-3
// RULE23: destination base in bits 22-0
// RULE24: nonzero height write starts the operation
// RULE25: pattern tiled by column and row modulo 8
module blit_pattern_fetch (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [3:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [31:0] REG_RDATA_OUT,
  output logic             MEM_RD_OUT,
  output logic             MEM_WR_OUT,
  output logic      [19:0] MEM_QADDR_OUT,
  output logic      [7:0]  MEM_BE_OUT,
  output logic      [63:0] MEM_WDATA_OUT,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [63:0] MEM_RDATA_IN,
  output logic             HOST_VALID_OUT,
  output logic      [63:0] HOST_DATA_OUT,
  output logic      [7:0]  HOST_BE_OUT,
  input  wire logic        HOST_READY_IN,
  output logic             BUSY_OUT,
  output logic             SRC_SHARED_OUT
);
  typedef enum logic [2:0] {
    S_IDLE, S_PAT, S_NEXT, S_DRD, S_DWR, S_HOST
  } state_type;

  state_type   state_q, state_d;
  logic [31:0] pitch_q, pitch_d, bg_q, bg_d, fg_q, fg_d;
  logic [31:0] msc_q, msc_d, ctl_q, ctl_d, pbase_q, pbase_d;
  logic [31:0] dbase_q, dbase_d, ext_q, ext_d, rdata_q, rdata_d;
  logic        mrd_q, mrd_d, mwr_q, mwr_d;
  logic [19:0] qaddr_q, qaddr_d;
  logic [7:0]  be_q, be_d;
  logic [63:0] wdata_q, wdata_d;
  logic        hval_q, hval_d;
  logic [63:0] hdata_q, hdata_d;
  logic [7:0]  hbe_q, hbe_d;
  logic [5:0]  pcnt_q, pcnt_d;
  logic [12:0] bx_q, bx_d, y_q, y_d;
  logic [2:0]  px_q, px_d, prow_q, prow_d, lane_q, lane_d;
  logic [1:0]  k_q, k_d;
  logic [22:0] row_q, row_d, baddr_q, baddr_d;
  logic        done_q, done_d;

  logic [63:0] pat_mem [0:blit_pkg::PAT_QWORDS-1];
  logic        pat_we;

  // decoded job settings
  logic        mono, to_host, need_rd, last_byte, row_end, pix_end;
  logic [1:0]  depth, bpp_m1;
  logic [7:0]  row_bytes, off, rop, pat_byte, color_byte, mono_row;
  logic [7:0]  dest_byte, res;
  logic [5:0]  pat_last;
  logic [12:0] wlast, hlast;
  logic [22:0] cur_addr;
  logic [63:0] pat_q;
  logic        mono_bit;

  always_comb begin
    mono    = ctl_q[blit_pkg::PAT_MONO_BIT]; // RULE11
    to_host = ctl_q[blit_pkg::DEST_HOST_BIT]; // RULE17
    depth   = ctl_q[blit_pkg::DEPTH_MSB:blit_pkg::DEPTH_LSB];
    rop     = ctl_q[blit_pkg::ROP_MSB:0];
    unique case (depth) // RULE3 RULE16
      blit_pkg::DEPTH_16: begin
        bpp_m1    = 2'h1;
        row_bytes = blit_pkg::ROW_BYTES_16;
      end
      blit_pkg::DEPTH_24: begin
        bpp_m1    = 2'h2;
        row_bytes = blit_pkg::ROW_BYTES_24; // RULE9
      end
      default: begin
        bpp_m1    = 2'h0;
        row_bytes = blit_pkg::ROW_BYTES_8;
      end
    endcase
    // last quadword index of the footprint; the fetch always covers the whole tile
    pat_last = mono ? (blit_pkg::MONO_QWORDS - 6'h01)
                    : (row_bytes[5:0] - 6'h01); // RULE2 RULE8
    // rop indexed as {pattern, source=0, destination}
    need_rd = !to_host &&
              ((rop[4] != rop[5]) || (rop[0] != rop[1])); // RULE15
    wlast   = ext_q[blit_pkg::WIDTH_MSB:0] - 13'h0001;
    hlast   = ext_q[blit_pkg::HEIGHT_MSB:blit_pkg::HEIGHT_LSB] - 13'h0001;
    row_end = (bx_q == wlast);
    pix_end = (k_q == bpp_m1);
    last_byte = row_end && (y_q == hlast);
    cur_addr  = row_q + {10'h000, bx_q};
  end

  // pattern pixel lookup; colour 24bpp rows use only the first 24 bytes,
  // the fourth bytes sit in the row's final quadword and are skipped
  always_comb begin
    off = (8'(prow_q) * row_bytes) + (8'(px_q) * 8'({1'b0, bpp_m1} + 3'h1))
          + 8'(k_q); // RULE9 RULE10 RULE25
    pat_q    = pat_mem[off[7:3]];
    pat_byte = pat_q[{off[2:0], 3'h0} +: 8];
    mono_row = pat_mem[0][{prow_q, 3'h0} +: 8];
    mono_bit = mono_row[3'h7 - px_q];
  end

  color_expand #(
    .COLOR_W (24)
  ) u_expand (
    .mono_bit_in (mono_bit),
    .fg_in       (fg_q[23:0]), // RULE14
    .bg_in       (bg_q[23:0]), // RULE14
    .byte_sel_in (k_q),
    .byte_out    (color_byte)
  );

  function automatic logic [7:0] apply_rop(input logic [7:0] r,
                                           input logic [7:0] p,
                                           input logic [7:0] d);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      o[i] = r[{p[i], 1'b0, d[i]}];
    end
    return o;
  endfunction

  always_comb begin
    dest_byte = (state_q == S_DRD) ?
                MEM_RDATA_IN[{baddr_q[2:0], 3'h0} +: 8] : 8'h00;
    res = apply_rop(rop, mono ? color_byte : pat_byte, dest_byte);
  end

  // register port and job sequencing
  always_comb begin
    pitch_d = pitch_q;
    bg_d    = bg_q;
    fg_d    = fg_q;
    msc_d   = msc_q;
    ctl_d   = ctl_q;
    pbase_d = pbase_q;
    dbase_d = dbase_q;
    ext_d   = ext_q;
    rdata_d = 32'h0000_0000;
    state_d = state_q;
    mrd_d   = mrd_q;
    mwr_d   = mwr_q;
    qaddr_d = qaddr_q;
    be_d    = be_q;
    wdata_d = wdata_q;
    hval_d  = hval_q;
    hdata_d = hdata_q;
    hbe_d   = hbe_q;
    pcnt_d  = pcnt_q;
    bx_d    = bx_q;
    y_d     = y_q;
    px_d    = px_q;
    prow_d  = prow_q;
    lane_d  = lane_q;
    k_d     = k_q;
    row_d   = row_q;
    baddr_d = baddr_q;
    done_d  = done_q;
    pat_we  = 1'b0;

    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        blit_pkg::LINE_PITCH_IDX:   rdata_d = pitch_q;
        blit_pkg::EXPAND_BG_IDX:    rdata_d = bg_q;
        blit_pkg::EXPAND_FG_IDX:    rdata_d = fg_q;
        blit_pkg::MONO_SRC_CTL_IDX: rdata_d = msc_q;
        blit_pkg::BLIT_CTL_IDX: begin
          rdata_d = ctl_q;
          rdata_d[blit_pkg::BUSY_BIT] = (state_q != S_IDLE);
        end
        blit_pkg::PAT_BASE_IDX:     rdata_d = pbase_q;
        blit_pkg::DEST_BASE_IDX:    rdata_d = dbase_q;
        blit_pkg::DEST_EXTENT_IDX:  rdata_d = ext_q;
        default:                    rdata_d = 32'h0000_0000;
      endcase
    end

    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        blit_pkg::LINE_PITCH_IDX:
          pitch_d = REG_WDATA_IN & blit_pkg::PITCH_MASK; // RULE21
        blit_pkg::EXPAND_BG_IDX:
          bg_d = REG_WDATA_IN & blit_pkg::COLOR_MASK;
        blit_pkg::EXPAND_FG_IDX:
          fg_d = REG_WDATA_IN & blit_pkg::COLOR_MASK;
        blit_pkg::MONO_SRC_CTL_IDX:
          msc_d = REG_WDATA_IN;
        blit_pkg::BLIT_CTL_IDX:
          ctl_d = REG_WDATA_IN & blit_pkg::CTL_MASK;
        blit_pkg::PAT_BASE_IDX:
          pbase_d = REG_WDATA_IN & blit_pkg::PAT_BASE_MASK; // RULE4 RULE22
        blit_pkg::DEST_BASE_IDX:
          dbase_d = REG_WDATA_IN & blit_pkg::DEST_MASK; // RULE23
        blit_pkg::DEST_EXTENT_IDX:
          // a busy engine keeps its extent; the write is dropped
          if (state_q == S_IDLE) begin
            ext_d = REG_WDATA_IN & blit_pkg::EXTENT_MASK;
          end
        default: ;
      endcase
    end

    unique case (state_q)
      S_IDLE: begin
        if (REG_WR_IN && REG_ADDR_IN == blit_pkg::DEST_EXTENT_IDX &&
            REG_WDATA_IN[blit_pkg::HEIGHT_MSB:blit_pkg::HEIGHT_LSB]
              != 13'h0000) begin // RULE24
          state_d = S_PAT;
          mrd_d   = 1'b1; // RULE1
          be_d    = 8'hff;
          qaddr_d = pbase_q[blit_pkg::PAT_BASE_MSB:
                            blit_pkg::PAT_BASE_LSB]; // RULE4
          pcnt_d  = 6'h00;
          bx_d    = 13'h0000;
          y_d     = 13'h0000;
          px_d    = 3'h0;
          k_d     = 2'h0;
          prow_d  = ctl_q[blit_pkg::PAT_ROW_MSB:blit_pkg::PAT_ROW_LSB];
          row_d   = to_host ? 23'h000000
                            : dbase_q[blit_pkg::DEST_MSB:0]; // RULE19
          lane_d  = dbase_q[blit_pkg::HOST_LANE_MSB:0]; // RULE18
          hdata_d = 64'h0;
          hbe_d   = 8'h00;
          done_d  = 1'b0;
        end
      end
      S_PAT: begin
        if (MEM_ACK_IN) begin
          pat_we = 1'b1;
          pcnt_d = pcnt_q + 6'h01;
          qaddr_d = qaddr_q + 20'h00001;
          if (pcnt_q == pat_last) begin // RULE8
            mrd_d   = 1'b0;
            state_d = S_NEXT;
          end
        end
      end
      S_NEXT: begin
        baddr_d = cur_addr;
        qaddr_d = cur_addr[22:3];
        be_d    = 8'h01 << cur_addr[2:0];
        if (to_host) begin
          hdata_d[{lane_q, 3'h0} +: 8] = res;
          hbe_d[lane_q] = 1'b1;
          lane_d = lane_q + 3'h1;
          done_d = last_byte;
          if (lane_q == 3'h7 || last_byte) begin
            hval_d  = 1'b1;
            state_d = S_HOST;
          end
        end else if (need_rd) begin
          mrd_d   = 1'b1; // RULE15
          state_d = S_DRD;
        end else begin
          mwr_d   = 1'b1;
          wdata_d = {8{res}}; // RULE16
          state_d = S_DWR;
        end
        done_d = last_byte;
      end
      S_DRD: begin
        if (MEM_ACK_IN) begin
          mrd_d   = 1'b0;
          mwr_d   = 1'b1;
          wdata_d = {8{res}}; // RULE15
          state_d = S_DWR;
        end
      end
      S_DWR: begin
        if (MEM_ACK_IN) begin
          mwr_d   = 1'b0;
          state_d = done_q ? S_IDLE : S_NEXT;
        end
      end
      S_HOST: begin
        if (HOST_READY_IN) begin
          hval_d  = 1'b0;
          hdata_d = 64'h0;
          hbe_d   = 8'h00;
          state_d = done_q ? S_IDLE : S_NEXT;
        end
      end
      default: state_d = S_IDLE;
    endcase

    // step to the next destination byte once this one is consumed
    if (state_q == S_NEXT && to_host ||
        state_q == S_DWR && MEM_ACK_IN && !done_q) begin
      if (row_end) begin
        bx_d   = 13'h0000;
        px_d   = 3'h0;
        k_d    = 2'h0;
        y_d    = y_q + 13'h0001;
        prow_d = prow_q + 3'h1; // RULE25
        row_d  = row_q + {10'h000,
          pitch_q[blit_pkg::DPITCH_MSB:blit_pkg::DPITCH_LSB]}; // RULE21
      end else begin
        bx_d = bx_q + 13'h0001;
        k_d  = pix_end ? 2'h0 : k_q + 2'h1; // RULE13
        px_d = pix_end ? px_q + 3'h1 : px_q; // RULE25
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (pat_we) begin
      pat_mem[pcnt_q[4:0]] <= MEM_RDATA_IN; // RULE1
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_q <= S_IDLE;
      pitch_q <= 32'h0000_0000;
      bg_q    <= 32'h0000_0000;
      fg_q    <= 32'h0000_0000;
      msc_q   <= 32'h0000_0000;
      ctl_q   <= 32'h0000_0000;
      pbase_q <= 32'h0000_0000;
      dbase_q <= 32'h0000_0000;
      ext_q   <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      mrd_q   <= 1'b0;
      mwr_q   <= 1'b0;
      qaddr_q <= 20'h00000;
      be_q    <= 8'h00;
      wdata_q <= 64'h0;
      hval_q  <= 1'b0;
      hdata_q <= 64'h0;
      hbe_q   <= 8'h00;
      pcnt_q  <= 6'h00;
      bx_q    <= 13'h0000;
      y_q     <= 13'h0000;
      px_q    <= 3'h0;
      prow_q  <= 3'h0;
      lane_q  <= 3'h0;
      k_q     <= 2'h0;
      row_q   <= 23'h000000;
      baddr_q <= 23'h000000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pitch_q <= pitch_d;
      bg_q    <= bg_d;
      fg_q    <= fg_d;
      msc_q   <= msc_d;
      ctl_q   <= ctl_d;
      pbase_q <= pbase_d;
      dbase_q <= dbase_d;
      ext_q   <= ext_d;
      rdata_q <= rdata_d;
      mrd_q   <= mrd_d;
      mwr_q   <= mwr_d;
      qaddr_q <= qaddr_d;
      be_q    <= be_d;
      wdata_q <= wdata_d;
      hval_q  <= hval_d;
      hdata_q <= hdata_d;
      hbe_q   <= hbe_d;
      pcnt_q  <= pcnt_d;
      bx_q    <= bx_d;
      y_q     <= y_d;
      px_q    <= px_d;
      prow_q  <= prow_d;
      lane_q  <= lane_d;
      k_q     <= k_d;
      row_q   <= row_d;
      baddr_q <= baddr_d;
      done_q  <= done_d;
    end
  end

  // outputs straight from flops; busy and source select are registered
  logic busy_q, shared_q;
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      busy_q   <= 1'b0;
      shared_q <= 1'b0;
    end else begin
      busy_q   <= (state_d != S_IDLE);
      shared_q <= msc_d[blit_pkg::SRC_SHARED_BIT]; // RULE14
    end
  end

  assign REG_RDATA_OUT  = rdata_q;
  assign MEM_RD_OUT     = mrd_q;
  assign MEM_WR_OUT     = mwr_q;
  assign MEM_QADDR_OUT  = qaddr_q;
  assign MEM_BE_OUT     = be_q;
  assign MEM_WDATA_OUT  = wdata_q;
  assign HOST_VALID_OUT = hval_q;
  assign HOST_DATA_OUT  = hdata_q;
  assign HOST_BE_OUT    = hbe_q;
  assign BUSY_OUT       = busy_q;
  assign SRC_SHARED_OUT = shared_q;
endmodule

/* File: blit_checker_asserts.sv */
`timescale 1ns/10ps
module blit_checker (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [3:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        MEM_RD_OUT,
  input  wire logic        MEM_WR_OUT,
  input  wire logic [19:0] MEM_QADDR_OUT,
  input  wire logic [7:0]  MEM_BE_OUT,
  input  wire logic [63:0] MEM_WDATA_OUT,
  input  wire logic        MEM_ACK_IN,
  input  wire logic        HOST_VALID_OUT,
  input  wire logic [63:0] HOST_DATA_OUT,
  input  wire logic [7:0]  HOST_BE_OUT,
  input  wire logic        HOST_READY_IN,
  input  wire logic        BUSY_OUT,
  input  wire logic        SRC_SHARED_OUT
);
  logic [19:0] pat_q;
  logic [19:0] pat_d;
  logic        host_q;
  logic        host_d;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // shadows of the registers that the checks depend on
  always_comb begin
    pat_d = pat_q;
    host_d = host_q;
    if (REG_WR_IN && REG_ADDR_IN == 4'h5) pat_d = REG_WDATA_IN[22:3];
    if (REG_WR_IN && REG_ADDR_IN == 4'h4) host_d = REG_WDATA_IN[11];
  end

  always_ff @(posedge CLK_IN) begin
    pat_q <= SYS_RST_IN ? 20'h0 : pat_d;
    host_q <= SYS_RST_IN ? 1'b0 : host_d;
  end

  sequence s_go;
    REG_WR_IN && REG_ADDR_IN == 4'h8 && REG_WDATA_IN[28:16] != 13'h0
      && !BUSY_OUT;
  endsequence

  sequence s_fetch;
    BUSY_OUT && MEM_RD_OUT && MEM_QADDR_OUT == pat_q;
  endsequence

  AST_START: assert property (s_go |=> s_fetch)
    else $error("start did not fetch pattern base");
  AST_NO_START: assert property (REG_WR_IN && REG_ADDR_IN == 4'h8
    && REG_WDATA_IN[28:16] == 13'h0 && !BUSY_OUT |=> !BUSY_OUT)
    else $error("zero height started the engine");
  AST_RD_HOLD: assert property (MEM_RD_OUT && !MEM_ACK_IN
    |=> MEM_RD_OUT && $stable(MEM_QADDR_OUT))
    else $error("memory read dropped before ack");
  AST_WR_HOLD: assert property (MEM_WR_OUT && !MEM_ACK_IN
    |=> MEM_WR_OUT && $stable(MEM_WDATA_OUT) && $stable(MEM_BE_OUT))
    else $error("memory write changed before ack");
  AST_WR_LANE: assert property (MEM_WR_OUT |-> $onehot(MEM_BE_OUT)
    && MEM_WDATA_OUT == {8{MEM_WDATA_OUT[7:0]}})
    else $error("destination write not one byte");
  AST_HOST_NO_FB: assert property (BUSY_OUT && host_q |-> !MEM_WR_OUT)
    else $error("host destination wrote frame buffer");
  AST_FB_NO_HOST: assert property (!host_q |-> !HOST_VALID_OUT)
    else $error("frame buffer destination offered host data");
  AST_HOST_HOLD: assert property (HOST_VALID_OUT && !HOST_READY_IN
    |=> HOST_VALID_OUT && $stable(HOST_DATA_OUT) && $stable(HOST_BE_OUT))
    else $error("host quadword changed before accept");
  AST_SHARED: assert property (REG_WR_IN && REG_ADDR_IN == 4'h3
    |-> ##2 SRC_SHARED_OUT == $past(REG_WDATA_IN[27], 2))
    else $error("shared colour select not followed");
endmodule

bind blit_pattern_fetch blit_checker chk_u (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .MEM_RD_OUT(MEM_RD_OUT), .MEM_WR_OUT(MEM_WR_OUT),
  .MEM_QADDR_OUT(MEM_QADDR_OUT), .MEM_BE_OUT(MEM_BE_OUT),
  .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_ACK_IN(MEM_ACK_IN),
  .HOST_VALID_OUT(HOST_VALID_OUT), .HOST_DATA_OUT(HOST_DATA_OUT),
  .HOST_BE_OUT(HOST_BE_OUT), .HOST_READY_IN(HOST_READY_IN),
  .BUSY_OUT(BUSY_OUT), .SRC_SHARED_OUT(SRC_SHARED_OUT)
);

/* File: fb_host_model.sv */
`timescale 1ns/10ps
module fb_host_model (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [19:0] qaddr_in,
  input  wire logic [7:0]  be_in,
  input  wire logic [63:0] wdata_in,
  output logic             ack_out,
  output logic      [63:0] rdata_out,
  input  wire logic        hvalid_in,
  input  wire logic [63:0] hdata_in,
  input  wire logic [7:0]  hbe_in,
  output logic             hready_out
);
  logic [63:0] mem [int];
  logic [63:0] hq [$];
  logic [7:0]  hbq [$];
  logic [63:0] t;
  logic [2:0]  cnt;
  int          n_rd;
  int          n_wr;
  int          wait_n;

  // unwritten memory holds an address-derived pattern
  function automatic logic [63:0] dflt(input logic [19:0] a);
    return {12'h5a5, a, 12'ha5a, ~a};
  endfunction

  initial begin
    ack_out = 1'b0;
    rdata_out = 64'h0;
    hready_out = 1'b0;
    cnt = 3'h0;
    n_rd = 0;
    n_wr = 0;
    wait_n = 0;
  end

  always @(posedge clk_in) begin
    cnt <= cnt + 3'h1;
    hready_out <= !slow_in || (cnt[0] ^ cnt[2]);
    if (hvalid_in && hready_out) begin
      hq.push_back(hdata_in);
      hbq.push_back(hbe_in);
    end
    ack_out <= 1'b0;
    // released data bus toggles between the last word and its inverse
    rdata_out <= ~rdata_out;
    if (!ack_out && (rd_in || wr_in)) begin
      if (slow_in && wait_n < int'(cnt[1:0])) wait_n++;
      else begin
        wait_n = 0;
        ack_out <= 1'b1;
        t = mem.exists(qaddr_in) ? mem[qaddr_in] : dflt(qaddr_in);
        if (rd_in) begin
          n_rd++;
          rdata_out <= t;
        end else begin
          n_wr++;
          for (int i = 0; i < 8; i++)
            if (be_in[i]) t[8*i+:8] = wdata_in[8*i+:8];
          mem[qaddr_in] = t;
        end
      end
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst, rwr, rrd, mrd, mwr, mack, hval, hrdy;
  logic        busy, shared, slow;
  logic [3:0]  ra;
  logic [31:0] rwd, rdat, seed;
  logic [19:0] mqa;
  logic [7:0]  mbe, hbe;
  logic [63:0] mwd, mrdat, hdat;
  logic [63:0] fbm [int];
  int          num_errors;
  int          n_compared;

  blit_pattern_fetch dut_u (.CLK_IN(clk), .SYS_RST_IN(rst),
    .REG_ADDR_IN(ra), .REG_WDATA_IN(rwd), .REG_WR_IN(rwr), .REG_RD_IN(rrd),
    .REG_RDATA_OUT(rdat), .MEM_RD_OUT(mrd), .MEM_WR_OUT(mwr),
    .MEM_QADDR_OUT(mqa), .MEM_BE_OUT(mbe), .MEM_WDATA_OUT(mwd),
    .MEM_ACK_IN(mack), .MEM_RDATA_IN(mrdat), .HOST_VALID_OUT(hval),
    .HOST_DATA_OUT(hdat), .HOST_BE_OUT(hbe), .HOST_READY_IN(hrdy),
    .BUSY_OUT(busy), .SRC_SHARED_OUT(shared));
  fb_host_model partner_u (.clk_in(clk), .slow_in(slow), .rd_in(mrd),
    .wr_in(mwr), .qaddr_in(mqa), .be_in(mbe), .wdata_in(mwd),
    .ack_out(mack), .rdata_out(mrdat), .hvalid_in(hval), .hdata_in(hdat),
    .hbe_in(hbe), .hready_out(hrdy));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [63:0] dflt(input logic [19:0] a);
    return {12'h5a5, a, 12'ha5a, ~a};
  endfunction
  function automatic logic [7:0] mb(input logic [22:0] a);
    logic [63:0] q;
    q = fbm.exists(a[22:3]) ? fbm[a[22:3]] : dflt(a[22:3]);
    return q[8*a[2:0]+:8];
  endfunction
  function automatic logic [7:0] rop8(input logic [7:0] r, p, d);
    for (int i = 0; i < 8; i++) rop8[i] = r[{p[i], 1'b0, d[i]}];
  endfunction
  function automatic logic [63:0] bm(input logic [7:0] b);
    for (int i = 0; i < 8; i++) bm[8*i+:8] = {8{b[i]}};
  endfunction
  function automatic logic [31:0] msk(input int i);
    case (i)
      0: return blit_pkg::PITCH_MASK;
      1, 2: return blit_pkg::COLOR_MASK;
      3: return 32'hffff_ffff;
      4: return blit_pkg::CTL_MASK;
      5: return blit_pkg::PAT_BASE_MASK;
      7: return blit_pkg::DEST_MASK;
      8: return blit_pkg::EXTENT_MASK;
      default: return 32'h0;
    endcase
  endfunction

  task automatic results();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] e);
    n_compared++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
    @(posedge clk);
  endtask

  task automatic run_op(input logic [1:0] dp, input logic mo, ho,
                        input logic [7:0] rp);
    logic [31:0] pb, db, fg, bg, x;
    logic [12:0] w, h, pt;
    logic [2:0]  sr, ln;
    logic [7:0]  p, r, cbe;
    logic [63:0] cur, t;
    logic [22:0] a;
    logic [63:0] eq [$];
    logic [7:0]  eb [$];
    int          bpb, c, nr, nw, hs, i;
    bpb = dp + 1;
    w = 13'(bpb * (6 + rnd() % 6));
    h = 13'(3 + rnd() % 8);
    pt = w + 13'((rnd() % 2) * (rnd() % 40));
    x = rnd();
    sr = x[2:0];
    pb = 32'h40_0000 | (rnd() & 32'h3f_ff07);
    db = rnd() & 32'h1f_ffff;
    fg = rnd() & 32'hff_ffff;
    bg = rnd() & 32'hff_ffff;
    wr(4'h0, {3'h0, pt, 16'h0});
    wr(4'h1, bg);
    wr(4'h2, fg);
    wr(4'h3, {4'h0, x[5], 27'h0});
    wr(4'h4, {6'h0, dp, 1'b0, sr, 1'b0, mo, 6'h0, ho, 3'h0, rp});
    wr(4'h5, pb);
    wr(4'h7, db);
    cbe = 8'h0;
    cur = 64'h0;
    ln = db[2:0];
    for (int l = 0; l < h; l++)
      for (int k = 0; k < w; k++) begin
        a = 23'(db + l * pt + k);
        c = (k / bpb) % 8;
        i = (sr + l) % 8;
        if (mo) begin
          p = mb({pb[22:3], 3'h0} + 23'(i));
          p = p[7-c] ? fg[8*(k%bpb)+:8] : bg[8*(k%bpb)+:8];
        end else
          p = mb({pb[22:3], 3'h0} + 23'((i << 3 << dp) + c * bpb + k % bpb));
        r = rop8(rp, p, mb(a));
        if (ho) begin
          cur[8*ln+:8] = r;
          cbe[ln] = 1'b1;
          ln = ln + 3'h1;
          if (ln == 3'h0) begin
            eq.push_back(cur);
            eb.push_back(cbe);
            cbe = 8'h0;
          end
        end else begin
          t = fbm.exists(a[22:3]) ? fbm[a[22:3]] : dflt(a[22:3]);
          t[8*a[2:0]+:8] = r;
          fbm[a[22:3]] = t;
        end
      end
    if (cbe != 8'h0) begin
      eq.push_back(cur);
      eb.push_back(cbe);
    end
    nr = partner_u.n_rd;
    nw = partner_u.n_wr;
    hs = partner_u.hq.size();
    wr(4'h8, {3'h0, h, 3'h0, w});
    chk(busy, 64'h1);
    chk(shared, 64'(x[5]));
    wr(4'h8, 32'h0001_0001);
    for (i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      num_errors++;
      results();
    end
    rd(4'h8, {3'h0, h, 3'h0, w});
    chk(64'(partner_u.n_rd - nr), 64'((mo ? 1 : 8 << dp) + ((rp[4] != rp[5]
      || rp[0] != rp[1]) && !ho ? w * h : 0)));
    chk(64'(partner_u.n_wr - nw), 64'(ho ? 0 : w * h));
    chk(64'(partner_u.hq.size() - hs), 64'(eq.size()));
    for (i = 0; i < eq.size() && hs + i < partner_u.hq.size(); i++) begin
      chk(partner_u.hbq[hs+i], eb[i]);
      chk(partner_u.hq[hs+i] & bm(eb[i]), eq[i] & bm(eb[i]));
    end
    foreach (fbm[q])
      chk(partner_u.mem.exists(q) ? partner_u.mem[q] : 64'h0, fbm[q]);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    logic [31:0] x;
    rst = 1'b1;
    ra = 4'h0;
    rwd = 32'h0;
    rwr = 1'b0;
    rrd = 1'b0;
    slow = 1'b0;
    seed = 32'hd09984d9;
    num_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) rd(4'(i), 32'h0);
    for (int i = 0; i < 16; i++) begin
      x = rnd();
      // zero height must leave the engine idle
      if (i == 8) x[28:16] = 13'h0;
      wr(4'(i), x);
      rd(4'(i), x & msk(i));
    end
    chk(busy, 64'h0);
    for (int n = 0; n < 12; n++) begin
      slow <= n[0] ^ n[2];
      run_op(2'(n % 3), (n / 3) % 2 == 1, n >= 6,
             n >= 6 ? 8'h0f : (n[0] ? 8'h5a : 8'hf0));
    end
    results();
  end
endmodule
